// ==== src/rt_mode_pkg.sv ====
// constants for the remote terminal mode command and status word handler
package rt_mode_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_VECTOR  = 8'h04;
  localparam logic [7:0] OFF_BITWORD = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_LASTCMD = 8'h10;

  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [15:0] VECTOR_RST  = 16'h0000;
  localparam logic [15:0] BITWORD_RST = 16'h0000;
  localparam logic [15:0] LASTCMD_RST = 16'h0000;

  // control register fields
  localparam int CTRL_SVC    = 0;
  localparam int CTRL_SUBSYS = 1;
  localparam int CTRL_FAIL   = 2;
  localparam int CTRL_BLOCK  = 3;
  localparam int CTRL_TFAULT = 4;
  localparam int CTRL_W      = 5;

  // ------------------------------------------------------------------
  // status word layout (bit time 9 sits at bit 10, bit time 19 at bit 0)
  // ------------------------------------------------------------------
  localparam int ST_ADDR_HI = 15;
  localparam int ST_ADDR_LO = 11;
  localparam int ST_MSG_ERR = 10;
  localparam int ST_INSTR   = 9;
  localparam int ST_SVC     = 8;
  localparam int ST_RSV_HI  = 7;
  localparam int ST_RSV_LO  = 5;
  localparam int ST_BCAST   = 4;
  localparam int ST_BUSY    = 3;
  localparam int ST_SUBSYS  = 2;
  localparam int ST_DBCA    = 1;
  localparam int ST_TFLAG   = 0;

  // pass/fail position in the built-in-test word, 1 means no-go
  localparam int BIT_NOGO = 0;

  // ------------------------------------------------------------------
  // command word fields and codes
  // ------------------------------------------------------------------
  localparam int CW_TR = 10;

  localparam logic [4:0] SA_MODE_A   = 5'h00;
  localparam logic [4:0] SA_MODE_B   = 5'h1F;
  localparam logic [4:0] ADDR_BCAST  = 5'h1F;
  localparam logic [4:0] ADDR_TERM_A = 5'h03;
  localparam logic [4:0] ADDR_TERM_B = 5'h08;
  localparam logic [4:0] SA_A_LO     = 5'h07;
  localparam logic [4:0] SA_A_HI     = 5'h1D;
  localparam logic [4:0] SA_B_0      = 5'h02;
  localparam logic [4:0] SA_B_1      = 5'h04;
  localparam logic [4:0] SA_B_2      = 5'h0E;
  localparam logic [4:0] SA_B_3      = 5'h12;
  localparam logic [4:0] SA_B_4      = 5'h18;
  localparam logic [4:0] SA_B_5      = 5'h1D;

  localparam logic [4:0] MC_SYNC       = 5'h01;
  localparam logic [4:0] MC_TX_STATUS  = 5'h02;
  localparam logic [4:0] MC_SELF_TEST  = 5'h03;
  localparam logic [4:0] MC_TX_SHUT    = 5'h04;
  localparam logic [4:0] MC_OVR_SHUT   = 5'h05;
  localparam logic [4:0] MC_INH_TF     = 5'h06;
  localparam logic [4:0] MC_OVR_INH_TF = 5'h07;
  localparam logic [4:0] MC_RESET      = 5'h08;
  localparam logic [4:0] MC_TX_VECTOR  = 5'h10;
  localparam logic [4:0] MC_SYNC_DATA  = 5'h11;
  localparam logic [4:0] MC_TX_LAST    = 5'h12;
  localparam logic [4:0] MC_TX_BIT     = 5'h13;
  localparam logic [4:0] MC_SEL_SHUT   = 5'h14;
  localparam logic [4:0] MC_OVR_SEL    = 5'h15;

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== src/rt_mode_status_handler.sv ====
// remote terminal mode command screening and status word builder
module rt_mode_status_handler
  import rt_mode_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic [4:0]  RT_ADDR,
  input  wire logic        CMD_VALID,
  input  wire logic [15:0] CMD_WORD,
  output logic             RESP_VALID,
  output logic [15:0]      RESP_STATUS,
  output logic             RESP_DATA_VALID,
  output logic [15:0]      RESP_DATA,
  output logic             CMD_ILLEGAL,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  typedef struct packed {
    logic              aw_full;
    logic [7:0]        aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       vector;
    logic [15:0]       bitword;
    logic [15:0]       last_cmd;
    logic              msg_err;
    logic              bcast_rcvd;
    logic              resp_valid;
    logic [15:0]       resp_status;
    logic              data_valid;
    logic [15:0]       resp_data;
    logic              illegal;
  } state_t;

  localparam state_t STATE_RST = '{
    ctrl: CTRL_RST, vector: VECTOR_RST, bitword: BITWORD_RST,
    last_cmd: LASTCMD_RST, default: '0};

  logic [1:0] rst_sync;
  logic       rst_n;
  state_t     s;
  state_t     next_s;

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic logic is_mode(input logic [15:0] cmd);
    return cmd[9:5] == SA_MODE_A || cmd[9:5] == SA_MODE_B;
  endfunction

  function automatic logic is_illegal(input logic [15:0] cmd,
                                      input logic [4:0]  rt);
    logic [4:0] sa;
    logic       bad;
    sa  = cmd[9:5];
    bad = 1'b0;
    if (is_mode(cmd)) begin
      // synchronize with and without data, selected shutdowns and reserved codes
      // fall into the default arm
      case (cmd[4:0])
        MC_TX_STATUS, MC_SELF_TEST, MC_TX_SHUT, MC_OVR_SHUT, MC_INH_TF,
        MC_OVR_INH_TF, MC_RESET, MC_TX_VECTOR, MC_TX_LAST,
        MC_TX_BIT: bad = 1'b0;
        default:   bad = 1'b1;
      endcase
    end else if (rt == ADDR_TERM_A) begin
      bad = sa >= SA_A_LO && sa <= SA_A_HI;
    end else if (rt == ADDR_TERM_B) begin
      bad = sa == SA_B_0 || sa == SA_B_1 || sa == SA_B_2 ||
            sa == SA_B_3 || sa == SA_B_4 || sa == SA_B_5;
    end
    return bad;
  endfunction

  function automatic logic [15:0] status_word(input logic [4:0]        rt,
                                              input logic              me,
                                              input logic              bc,
                                              input logic [CTRL_W-1:0] c);
    logic [15:0] w;
    w = 16'h0000;  // spare bits stay zero
    w[ST_ADDR_HI:ST_ADDR_LO] = rt;
    w[ST_MSG_ERR] = me;
    w[ST_SVC]     = c[CTRL_SVC];
    w[ST_BCAST]   = bc;
    w[ST_BUSY]    = c[CTRL_FAIL] | c[CTRL_BLOCK];
    w[ST_SUBSYS]  = c[CTRL_SUBSYS];
    w[ST_TFLAG]   = c[CTRL_TFAULT];
    return w;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic        addressed;
    logic        bcast;
    logic        ill;
    logic        mode_ok;
    logic [4:0]  mc;
    logic [31:0] wr;
    addressed = 1'b0;
    bcast     = 1'b0;
    ill       = 1'b0;
    mode_ok   = 1'b0;
    mc        = CMD_WORD[4:0];
    wr        = 32'h0000_0000;
    next_s    = s;
    next_s.resp_valid = 1'b0;
    next_s.data_valid = 1'b0;
    next_s.illegal    = 1'b0;

    // command screening
    bcast     = CMD_WORD[15:11] == ADDR_BCAST;
    addressed = CMD_VALID && (CMD_WORD[15:11] == RT_ADDR || bcast);
    ill       = is_illegal(CMD_WORD, RT_ADDR);
    mode_ok   = is_mode(CMD_WORD) && !ill;
    if (addressed) begin
      next_s.illegal = ill;
      // status and last-command requests must not disturb what they report
      if (!(mode_ok && (mc == MC_TX_STATUS || mc == MC_TX_LAST))) begin
        next_s.msg_err    = ill;
        next_s.bcast_rcvd = bcast;
        next_s.last_cmd   = CMD_WORD;
      end
      if (mode_ok && mc == MC_RESET) begin
        next_s.msg_err        = 1'b0;
        next_s.bcast_rcvd     = 1'b0;
        next_s.ctrl[CTRL_SVC] = 1'b0;
      end
      if (mode_ok && mc == MC_TX_VECTOR && !bcast) begin
        next_s.ctrl[CTRL_SVC] = 1'b0;
      end
      if (!bcast) begin
        next_s.resp_valid = 1'b1;
        // illegal commands never get data words
        next_s.data_valid = mode_ok && CMD_WORD[CW_TR] &&
                            (mc == MC_TX_VECTOR || mc == MC_TX_LAST ||
                             mc == MC_TX_BIT);
        case (mc)
          MC_TX_LAST: next_s.resp_data = s.last_cmd;
          MC_TX_BIT: begin
            next_s.resp_data = s.bitword;
            next_s.resp_data[BIT_NOGO] =
              s.ctrl[CTRL_TFAULT] | s.ctrl[CTRL_FAIL];
          end
          default: next_s.resp_data = s.vector;
        endcase
      end
      next_s.resp_status = status_word(RT_ADDR, next_s.msg_err,
                                       next_s.bcast_rcvd, next_s.ctrl);
    end

    // ----------------------------------------------------------------
    // register bus: write side
    // ----------------------------------------------------------------
    if (AWVALID && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (s.aw_addr)
        OFF_CTRL: begin
          wr = merge({27'h0, s.ctrl}, s.w_data, s.w_strb);
          // a software request wins over the clear by a vector command
          next_s.ctrl = wr[CTRL_W-1:0] |
                        {{(CTRL_W-1){1'b0}}, next_s.ctrl[CTRL_SVC]} &
                        {{(CTRL_W-1){1'b0}}, wr[CTRL_SVC]};
          next_s.ctrl[CTRL_SVC] = wr[CTRL_SVC] &
                                  (next_s.ctrl[CTRL_SVC] | ~s.ctrl[CTRL_SVC]
                                   | s.w_strb[0]);
        end
        OFF_VECTOR: begin
          wr = merge({16'h0000, s.vector}, s.w_data, s.w_strb);
          next_s.vector = wr[15:0];
        end
        OFF_BITWORD: begin
          wr = merge({16'h0000, s.bitword}, s.w_data, s.w_strb);
          next_s.bitword = wr[15:0];
        end
        OFF_STATUS, OFF_LASTCMD: next_s.bresp = RESP_OKAY;
        default:                 next_s.bresp = RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;

    // ----------------------------------------------------------------
    // register bus: read side, answered one cycle after acceptance
    // ----------------------------------------------------------------
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ARVALID && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (ARADDR)
        OFF_CTRL:    next_s.rdata = {27'h0, s.ctrl};
        OFF_VECTOR:  next_s.rdata = {16'h0000, s.vector};
        OFF_BITWORD: next_s.rdata = {16'h0000, s.bitword};
        OFF_STATUS:  next_s.rdata = {16'h0000, status_word(RT_ADDR,
                                     s.msg_err, s.bcast_rcvd, s.ctrl)};
        OFF_LASTCMD: next_s.rdata = {16'h0000, s.last_cmd};
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign RESP_VALID      = s.resp_valid;
  assign RESP_STATUS     = s.resp_status;
  assign RESP_DATA_VALID = s.data_valid;
  assign RESP_DATA       = s.resp_data;
  assign CMD_ILLEGAL     = s.illegal;
  assign AWREADY         = s.awready;
  assign WREADY          = s.wready;
  assign BVALID          = s.bvalid;
  assign BRESP           = s.bresp;
  assign ARREADY         = s.arready;
  assign RVALID          = s.rvalid;
  assign RRESP           = s.rresp;
  assign RDATA           = s.rdata;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n || !CE);

  sequence own_cmd_s;
    CMD_VALID && CMD_WORD[15:11] == RT_ADDR && RT_ADDR != ADDR_BCAST;
  endsequence

  sequence ill_cmd_s;
    own_cmd_s and is_illegal(CMD_WORD, RT_ADDR);
  endsequence

  sequence mode_req_s(logic [4:0] code);
    own_cmd_s and is_mode(CMD_WORD) && CMD_WORD[4:0] == code;
  endsequence

  ill_resp_a: assert property (ill_cmd_s ##1 CE |->
    CMD_ILLEGAL && RESP_VALID && RESP_STATUS[ST_MSG_ERR] && !RESP_DATA_VALID)
    else $error("illegal command not answered with message error only");
  sync_data_a: assert property (mode_req_s(MC_SYNC_DATA) |=>
    CMD_ILLEGAL)
    else $error("synchronize with data word was accepted");
  sel_shut_a: assert property ((mode_req_s(MC_SEL_SHUT) or
    mode_req_s(MC_OVR_SEL)) |=> CMD_ILLEGAL)
    else $error("selected shutdown command was accepted");
  term_a_sa_a: assert property (own_cmd_s and
    (RT_ADDR == ADDR_TERM_A && CMD_WORD[9:5] == 5'h10) |=> CMD_ILLEGAL)
    else $error("listed subaddress not flagged");
  instr_zero_a: assert property (RESP_VALID |->
    !RESP_STATUS[ST_INSTR] && !RESP_STATUS[ST_DBCA])
    else $error("instrumentation or bus control bit set");
  rsv_zero_a: assert property (RESP_VALID |->
    RESP_STATUS[ST_RSV_HI:ST_RSV_LO] == 3'h0)
    else $error("reserved status bits not zero");
  busy_cause_a: assert property (own_cmd_s |=>
    RESP_STATUS[ST_BUSY] == ($past(s.ctrl[CTRL_FAIL]) |
                             $past(s.ctrl[CTRL_BLOCK])))
    else $error("busy bit does not match its causes");
  tflag_a: assert property (own_cmd_s |=>
    RESP_STATUS[ST_TFLAG] == $past(s.ctrl[CTRL_TFAULT]))
    else $error("terminal flag does not follow the fault");
  bit_word_a: assert property (mode_req_s(MC_TX_BIT) and
    CMD_WORD[CW_TR] |=> RESP_DATA_VALID &&
    RESP_DATA[BIT_NOGO] == $past(s.ctrl[CTRL_TFAULT] | s.ctrl[CTRL_FAIL]))
    else $error("test word pass/fail bit wrong");
  last_cmd_a: assert property (mode_req_s(MC_TX_LAST) and
    CMD_WORD[CW_TR] |=> RESP_DATA_VALID && RESP_DATA == $past(s.last_cmd))
    else $error("last command word not returned");
  bcast_bit_a: assert property (CMD_VALID &&
    CMD_WORD[15:11] == ADDR_BCAST && !is_mode(CMD_WORD) |=>
    !RESP_VALID && s.bcast_rcvd)
    else $error("broadcast not recorded or answered");
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write answer dropped before taken");

endmodule

// ==== dv/rt_bc_model.sv ====
// bus controller model that issues command words to the terminal
module rt_bc_model
  import rt_mode_pkg::*;
#(
  parameter int SELFTEST_GAP = 50
)(
  input  wire logic        clk,
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_status,
  output logic             cmd_valid,
  output logic [15:0]      cmd_word,
  output logic             recover
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int st_cyc = -SELFTEST_GAP;
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    recover = 1'b0;
  end
  // busy reactions are kept apart for each terminal address
  logic [31:0] busy_seen = 32'h0000_0000;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // one pulse for every status word that starts recovery
    recover <= resp_valid && resp_status[ST_MSG_ERR];
    if (resp_valid && resp_status[ST_BUSY]) begin
      busy_seen[resp_status[ST_ADDR_HI:ST_ADDR_LO]] <= 1'b1;
    end
  end
  // ------------------------------------------------------------------
  // one command word per call
  // ------------------------------------------------------------------
  task automatic send(input logic [15:0] w);
    logic md;
    md = (w[9:5] == SA_MODE_A) || (w[9:5] == SA_MODE_B);
    // gap scaled down from the real self-test time to keep the run short
    while (md && w[4:0] == MC_TX_BIT && cyc - st_cyc < SELFTEST_GAP) begin
      @(posedge clk);
    end
    if (md && w[4:0] == MC_SELF_TEST) begin
      st_cyc = cyc;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // a released word must not look like a held copy
    cmd_word <= ~w;
  endtask
endmodule

// ==== dv/rt_mode_status_handler_tb.sv ====
// testbench for the mode command and status word handler
module rt_mode_status_handler_tb;
  import rt_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] rt;
    logic [4:0] sa;
    logic       ill;
  } row_t;
  logic clk, rst_b, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] rt_addr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [1:0] r;
  logic resp_valid, resp_data_valid, cmd_illegal, cmd_valid, recover;
  logic [15:0] resp_status, resp_data, cmd_word;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ill;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  row_t rows [13] = '{'{5'h03, 5'h06, 1'b0}, '{5'h03, 5'h07, 1'b1},
    '{5'h03, 5'h10, 1'b1},
    '{5'h03, 5'h1D, 1'b1}, '{5'h03, 5'h1E, 1'b0}, '{5'h08, 5'h02, 1'b1},
    '{5'h08, 5'h03, 1'b0}, '{5'h08, 5'h04, 1'b1}, '{5'h08, 5'h0E, 1'b1},
    '{5'h08, 5'h12, 1'b1}, '{5'h08, 5'h18, 1'b1}, '{5'h08, 5'h1D, 1'b1},
    '{5'h08, 5'h1E, 1'b0}};

  rt_mode_status_handler rt_mode_status_handler_i (
    .CLK_SYS(clk), .RST_B(rst_b), .CE(ce), .RT_ADDR(rt_addr),
    .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .RESP_VALID(resp_valid),
    .RESP_STATUS(resp_status), .RESP_DATA_VALID(resp_data_valid),
    .RESP_DATA(resp_data), .CMD_ILLEGAL(cmd_illegal), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));
  rt_bc_model rt_bc_model_i (
    .clk(clk), .resp_valid(resp_valid), .resp_status(resp_status),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .recover(recover));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] cw(logic [4:0] a, logic t,
                                     logic [4:0] s, logic [4:0] c);
    return {a, t, s, c};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [15:0] w);
    rt_bc_model_i.send(w);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {ce, rt_addr, awaddr, araddr, wdata} = {1'b1, 5'h03, 48'h0};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk(d, (i == 3) ? 32'h0000_1800 : 32'h0000_0000);
    end
    rd(8'h20);
    chk(r, RESP_SLVERR);
    wr(8'h20, 32'h0000_0001);
    chk(r, RESP_SLVERR);
    foreach (rows[i]) begin
      @(posedge clk) rt_addr <= rows[i].rt;
      cmd(cw(rows[i].rt, 1'b0, rows[i].sa, 5'h02));
      chk({resp_valid, cmd_illegal, resp_data_valid, resp_status[10]},
          {1'b1, rows[i].ill, 1'b0, rows[i].ill});
    end
    @(posedge clk) rt_addr <= 5'h03;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 32; c++) begin
        ill = c <= 1 || (c >= 9 && c <= 15) || c == 17 || c >= 20;
        cmd(cw(5'h03, 1'b1, s ? SA_MODE_B : SA_MODE_A, 5'(c)));
        chk({resp_valid, cmd_illegal, resp_data_valid, resp_status[10]},
            {1'b1, ill, !ill && (c == 16 || c == 18 || c == 19),
             ill || c == 2 || c == 18});
      end
    end
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_RESET));
    wr(OFF_CTRL, 32'h0000_001F);
    wr(OFF_VECTOR, 32'h0000_5A5A);
    wr(OFF_BITWORD, 32'h0000_1234);
    rd(OFF_STATUS);
    chk(d, 32'h0000_190D);
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_VECTOR));
    chk({resp_data_valid, resp_data}, {1'b1, 16'h5A5A});
    rd(OFF_STATUS);
    chk(d, 32'h0000_180D);
    chk(rt_bc_model_i.busy_seen, 32'h0000_0008);
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_BIT));
    chk(resp_data, 16'h1235);
    wr(OFF_CTRL, 32'h0000_0000);
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_BIT));
    chk(resp_data, 16'h1234);
    cmd(cw(5'h1F, 1'b0, 5'h01, 5'h02));
    chk(resp_valid, 1'b0);
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_STATUS));
    chk(resp_status, 16'h1810);
    cmd(cw(5'h03, 1'b0, 5'h07, 5'h01));
    chk(recover, 1'b0);
    @(posedge clk) #1;
    chk(recover, 1'b1);
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_LAST));
    chk({resp_status[10], resp_data}, {1'b1, 16'h18E1});
    cmd(cw(5'h05, 1'b1, SA_MODE_A, MC_TX_STATUS));
    chk(resp_valid, 1'b0);
    @(posedge clk) ce <= 1'b0;
    cmd(cw(5'h03, 1'b1, SA_MODE_A, MC_TX_STATUS));
    chk(resp_valid, 1'b0);
    @(posedge clk) ce <= 1'b1;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_VECTOR);
    chk(d, 32'h0000_0000);
    close_out();
  end
endmodule
